// ### design/uie_pkg.sv
// Package for the interrupt-enable and frame counter block.
// Assumes a plain register port with 16-bit data at byte offsets.
package uie_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFS_FRAME_NUMBER = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h1C;
	// Event bit positions
	localparam int BIT_SUSPEND = 0;
	localparam int BIT_SOF = 2;
	localparam int BIT_BUS_RESET_END = 3;
	localparam int BIT_WAKE = 4;
	localparam int BIT_RESUME_END = 5;
	localparam int BIT_UPSTREAM_WAKE = 6;
	localparam int BIT_UNDERFLOW = 7;
	localparam int BIT_LPM_NOTYET = 8;
	localparam int BIT_LPM_SLEEP = 9;
	localparam logic [DATA_W-1:0] EVENT_MASK = 16'h03FD;
	localparam logic [DATA_W-1:0] ENABLE_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] FLAGS_RESET = 16'h0000;
	// Frame number field layout
	localparam int FRAME_LSB = 3;
	localparam int FRAME_W = 11;
	localparam int MICRO_W = 3;
	localparam int CRCERR_BIT = 15;
	// Suspend idle time
	localparam int CLOCK_HZ = 10_000_000;
	localparam int IDLE_SUSPEND_US = 3000;
	localparam int IDLE_SUSPEND_CYC = IDLE_SUSPEND_US * (CLOCK_HZ / 1_000_000);
	typedef enum logic [1:0] {
		UIE_ACTIVE = 2'b01,
		UIE_SUSPENDED = 2'b10
	} uie_idle_t;
endpackage

// ### design/uie_irq_frame.sv
// Interrupt enable vector, event flags and frame number counters.
// Assumes a USB line front end that delivers one-cycle event strobes
// and decoded frame numbers, and a register master on the plain port.
module uie_irq_frame #(
	parameter int IDLE_CYCLES = uie_pkg::IDLE_SUSPEND_CYC
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [uie_pkg::ADDR_W-1:0] i_addr,
	input wire logic [uie_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [uie_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_bus_reset,
	input wire logic i_sof,
	input wire logic i_msof,
	input wire logic i_frame_crc_bad,
	input wire logic [uie_pkg::FRAME_W-1:0] i_frame_count,
	input wire logic [uie_pkg::MICRO_W-1:0] i_microframe_count,
	input wire logic i_line_idle_j,
	input wire logic i_bus_reset_end_irq,
	input wire logic i_line_wake,
	input wire logic i_resume_end_irq,
	input wire logic i_upstream_wake_irq,
	input wire logic i_buffer_underflow_irq,
	input wire logic i_link_pm_notyet_irq,
	input wire logic i_link_pm_sleep_irq,
	output logic o_irq
);
	import uie_pkg::*;

	localparam int CNT_W = $clog2(IDLE_CYCLES + 1);

	// Timer needs at least two idle cycles
	if (IDLE_CYCLES < 2)
	begin : g_idle_check
		$error("IDLE_CYCLES too small");
	end

	logic [DATA_W-1:0] enable_ff, nxt_enable;
	logic [DATA_W-1:0] flags_ff, nxt_flags;
	logic [FRAME_W-1:0] frame_ff, nxt_frame;
	logic [MICRO_W-1:0] micro_ff, nxt_micro;
	logic crcerr_ff, nxt_crcerr;
	logic [CNT_W-1:0] idle_cnt_ff, nxt_idle_cnt;
	uie_idle_t idle_st_ff, nxt_idle_st;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic irq_ff, nxt_irq;
	logic suspend_evt;
	logic [DATA_W-1:0] events;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// Suspend idle timer
	always_comb
	begin
		nxt_idle_cnt = idle_cnt_ff;
		nxt_idle_st = idle_st_ff;
		suspend_evt = 1'b0;
		case (idle_st_ff)
			UIE_ACTIVE:
			begin
				if (!i_line_idle_j || i_bus_reset)
					nxt_idle_cnt = '0;
				else if (idle_cnt_ff == CNT_W'(IDLE_CYCLES - 1))
				begin
					suspend_evt = 1'b1;
					nxt_idle_st = UIE_SUSPENDED;
					nxt_idle_cnt = '0;
				end
				else
					nxt_idle_cnt = idle_cnt_ff + CNT_W'(1);
			end
			UIE_SUSPENDED:
			begin
				if (!i_line_idle_j || i_bus_reset)
					nxt_idle_st = UIE_ACTIVE;
			end
			default:
			begin
				nxt_idle_st = UIE_ACTIVE;
				nxt_idle_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			idle_cnt_ff <= '0;
			idle_st_ff <= UIE_ACTIVE;
		end
		else
		begin
			idle_cnt_ff <= nxt_idle_cnt;
			idle_st_ff <= nxt_idle_st;
		end
	end

	// Event vector, bit placement
	always_comb
	begin
		events = '0;
		events[BIT_SUSPEND] = suspend_evt;
		events[BIT_SOF] = i_sof;
		events[BIT_BUS_RESET_END] = i_bus_reset_end_irq;
		events[BIT_WAKE] = i_line_wake;
		events[BIT_RESUME_END] = i_resume_end_irq;
		events[BIT_UPSTREAM_WAKE] = i_upstream_wake_irq;
		events[BIT_UNDERFLOW] = i_buffer_underflow_irq;
		events[BIT_LPM_NOTYET] = i_link_pm_notyet_irq;
		events[BIT_LPM_SLEEP] = i_link_pm_sleep_irq;
	end

	// Enable vector and event flags
	always_comb
	begin
		nxt_enable = enable_ff;
		nxt_flags = flags_ff;
		if (i_write && hit(i_addr, OFS_ENABLE_CLEAR))
			nxt_enable = enable_ff & ~i_wdata;
		if (i_write && hit(i_addr, OFS_ENABLE_SET))
			nxt_enable = (enable_ff | i_wdata) & EVENT_MASK;
		if (i_write && hit(i_addr, OFS_EVENT_FLAGS))
			nxt_flags = flags_ff & ~i_wdata;
		nxt_flags = (nxt_flags | events) & EVENT_MASK;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			enable_ff <= ENABLE_RESET;
			flags_ff <= FLAGS_RESET;
		end
		else
		begin
			enable_ff <= nxt_enable;
			flags_ff <= nxt_flags;
		end
	end

	// Frame number fields
	always_comb
	begin
		nxt_frame = frame_ff;
		nxt_micro = micro_ff;
		nxt_crcerr = crcerr_ff;
		if (i_bus_reset)
		begin
			nxt_frame = '0;
			nxt_micro = '0;
			nxt_crcerr = 1'b0;
		end
		else if (i_sof)
		begin
			nxt_frame = i_frame_count;
			nxt_micro = '0;
			nxt_crcerr = i_frame_crc_bad;
		end
		else if (i_msof)
		begin
			nxt_micro = i_microframe_count;
			nxt_crcerr = i_frame_crc_bad;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			frame_ff <= '0;
			micro_ff <= '0;
			crcerr_ff <= 1'b0;
		end
		else
		begin
			frame_ff <= nxt_frame;
			micro_ff <= nxt_micro;
			crcerr_ff <= nxt_crcerr;
		end
	end

	// Read data and interrupt request
	always_comb
	begin
		nxt_rdata = '0;
		if (i_read)
		begin
			if (hit(i_addr, OFS_ENABLE_CLEAR) || hit(i_addr, OFS_ENABLE_SET))
				nxt_rdata = enable_ff & EVENT_MASK;
			else if (hit(i_addr, OFS_EVENT_FLAGS))
				nxt_rdata = flags_ff;
			else if (hit(i_addr, OFS_FRAME_NUMBER))
			begin
				nxt_rdata[CRCERR_BIT] = crcerr_ff;
				nxt_rdata[FRAME_LSB +: FRAME_W] = frame_ff;
				nxt_rdata[MICRO_W-1:0] = micro_ff;
			end
		end
		nxt_irq = |(nxt_flags & nxt_enable);
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rdata_ff <= '0;
			irq_ff <= 1'b0;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_irq = irq_ff;

	frame_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_sof && !i_bus_reset) |=> frame_ff == $past(i_frame_count))
		else $error("frame count not loaded from SOF");
	micro_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_bus_reset || i_sof) |=> micro_ff == '0)
		else $error("micro-frame count not cleared");
	micro_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_msof && !i_sof && !i_bus_reset) |=> micro_ff == $past(i_microframe_count))
		else $error("micro-frame count not loaded");
	en_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_write && i_addr == OFS_ENABLE_CLEAR) |=> (enable_ff & $past(i_wdata)) == '0)
		else $error("enable bits not cleared");
	en_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_write && i_addr == OFS_ENABLE_SET) |=>
		(enable_ff & $past(i_wdata) & EVENT_MASK) == ($past(i_wdata) & EVENT_MASK))
		else $error("enable bits not set");
	en_readback_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_read && (i_addr == OFS_ENABLE_CLEAR || i_addr == OFS_ENABLE_SET)) |=> o_rdata == $past(enable_ff))
		else $error("enable readback mismatch");
	irq_level_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_irq == |($past(nxt_flags) & $past(nxt_enable)))
		else $error("interrupt level wrong");
	reserved_zero_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(enable_ff & ~EVENT_MASK) == '0)
		else $error("reserved enable bit set");
	sof_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_sof |=> flags_ff[BIT_SOF])
		else $error("SOF flag not set");
	flag_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_write && i_addr == OFS_EVENT_FLAGS && i_wdata[BIT_SOF] && !i_sof) |=> !flags_ff[BIT_SOF])
		else $error("flag not cleared by write one");
	frame_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_bus_reset |=> frame_ff == '0 && !crcerr_ff)
		else $error("frame count not cleared by bus reset");
	en_clear_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_write && i_addr == OFS_ENABLE_CLEAR) |=>
		(enable_ff & ~$past(i_wdata)) == ($past(enable_ff) & ~$past(i_wdata)))
		else $error("enable bit written zero changed by clear");
	en_set_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_write && i_addr == OFS_ENABLE_SET) |=>
		(enable_ff & ~$past(i_wdata)) == ($past(enable_ff) & ~$past(i_wdata)))
		else $error("enable bit written zero changed by set");
	irq_match_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_irq == |(flags_ff & enable_ff))
		else $error("interrupt differs from flags and enables");
	sleep_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_link_pm_sleep_irq |=> flags_ff[BIT_LPM_SLEEP])
		else $error("sleep flag not at its bit");
	wake_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_upstream_wake_irq |=> flags_ff[BIT_UPSTREAM_WAKE])
		else $error("upstream wake flag not at its bit");
	reset_end_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_bus_reset_end_irq |=> flags_ff[BIT_BUS_RESET_END])
		else $error("reset end flag not at its bit");
	reserved_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_read && i_addr != OFS_FRAME_NUMBER) |=> (o_rdata & ~EVENT_MASK) == '0)
		else $error("reserved bit read as one");
	suspend_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(idle_st_ff == UIE_ACTIVE && i_line_idle_j && !i_bus_reset && idle_cnt_ff == CNT_W'(IDLE_CYCLES - 1))
		|=> flags_ff[BIT_SUSPEND])
		else $error("suspend flag not set after idle time");
	flag_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(i_write && i_addr == OFS_EVENT_FLAGS) |=>
		(flags_ff & $past(flags_ff) & ~$past(i_wdata)) == ($past(flags_ff) & ~$past(i_wdata)))
		else $error("flag written zero was cleared");
endmodule

// ### verif/uie_host_model.sv
// Host side model that sends start-of-frame packets on command.
// Assumes the bench asks for one packet at a time, by a one-cycle request.
module uie_host_model (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_go_sof,
	input wire logic i_go_msof,
	input wire logic i_bad,
	input wire logic [10:0] i_num,
	output logic o_sof,
	output logic o_msof,
	output logic o_crc_bad,
	output logic [10:0] o_frame,
	output logic [2:0] o_micro
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sof <= 1'b0;
			o_msof <= 1'b0;
			o_crc_bad <= 1'b0;
			o_frame <= '0;
			o_micro <= '0;
		end
		else
		begin
			o_sof <= i_go_sof;
			o_msof <= i_go_msof;
			o_crc_bad <= (i_go_sof | i_go_msof) ? i_bad : ~o_crc_bad;
			o_frame <= i_go_sof ? i_num : ~o_frame;
			o_micro <= i_go_msof ? i_num[2:0] : ~o_micro;
		end
	end
endmodule

// ### verif/tb_top.sv
// Bench for the enable vector, event flags and frame number block.
// Assumes the host model in its own file and a small idle count.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import uie_pkg::*;
	logic i_clock = 0, i_rst_n = 0, i_write = 0, i_read = 0, i_bus_reset = 0, idle = 0;
	logic go_s = 0, go_m = 0, bad = 0, sof, msof, crc, o_irq;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0, o_rdata, en = '0, fl = '0;
	logic [10:0] num = '0, frame;
	logic [2:0] micro;
	logic [9:0] ev = '0;
	logic [31:0] lf = 32'h01338DE6;
	int num_errors = 0, num_checks = 0;
	always #50 i_clock = ~i_clock;
	uie_host_model host (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_go_sof(go_s), .i_go_msof(go_m), .i_bad(bad),
		.i_num(num), .o_sof(sof), .o_msof(msof), .o_crc_bad(crc), .o_frame(frame), .o_micro(micro));
	uie_irq_frame #(.IDLE_CYCLES(8)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_bus_reset(i_bus_reset),
		.i_sof(sof), .i_msof(msof), .i_frame_crc_bad(crc), .i_frame_count(frame), .i_microframe_count(micro),
		.i_line_idle_j(idle), .i_bus_reset_end_irq(ev[3]), .i_line_wake(ev[4]), .i_resume_end_irq(ev[5]),
		.i_upstream_wake_irq(ev[6]), .i_buffer_underflow_irq(ev[7]), .i_link_pm_notyet_irq(ev[8]),
		.i_link_pm_sleep_irq(ev[9]), .o_irq(o_irq));
	function automatic logic [31:0] nx(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
		if (a == OFS_ENABLE_CLEAR)
			en = en & ~(d & EVENT_MASK);
		if (a == OFS_ENABLE_SET)
			en = en | (d & EVENT_MASK);
		if (a == OFS_EVENT_FLAGS)
			fl = fl & ~d;
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] e);
		@(posedge i_clock);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1;
		chk("rdata", o_rdata, e);
		chk("irq", {15'h0, o_irq}, {15'h0, |(fl & en)});
	endtask
	task automatic evt(logic [9:0] m);
		@(posedge i_clock);
		ev <= m;
		@(posedge i_clock);
		ev <= '0;
		fl = fl | m;
		#1;
		chk("irq", {15'h0, o_irq}, {15'h0, |(fl & en)});
	endtask
	task automatic frm(logic s, logic m, logic [10:0] n, logic b);
		@(posedge i_clock);
		go_s <= s;
		go_m <= m;
		num <= n;
		bad <= b;
		@(posedge i_clock);
		go_s <= 1'b0;
		go_m <= 1'b0;
		@(posedge i_clock);
		fl[2] = fl[2] | s;
		#1;
		chk("irq", {15'h0, o_irq}, {15'h0, |(fl & en)});
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#3000000;
		num_errors++;
		test_done();
	end
	initial
	begin
		repeat (3) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd(OFS_ENABLE_CLEAR, 16'h0000);
		rd(OFS_ENABLE_SET, 16'h0000);
		rd(OFS_EVENT_FLAGS, 16'h0000);
		rd(OFS_FRAME_NUMBER, 16'h0000);
		rd(8'h04, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 12; i++)
		begin
			lf = nx(lf);
			wr(lf[0] ? OFS_ENABLE_SET : OFS_ENABLE_CLEAR, lf[31:16] & EVENT_MASK);
			rd(OFS_ENABLE_CLEAR, en);
			rd(OFS_ENABLE_SET, en);
		end
		$display("test enable done");
		for (int b = 3; b < 10; b++)
		begin
			wr(OFS_ENABLE_CLEAR, EVENT_MASK);
			wr(OFS_ENABLE_SET, 16'h0001 << b);
			evt(10'h001 << b);
			rd(OFS_EVENT_FLAGS, fl);
			wr(OFS_EVENT_FLAGS, 16'h0000);
			rd(OFS_EVENT_FLAGS, fl);
			wr(OFS_ENABLE_CLEAR, 16'h0001 << b);
			rd(OFS_EVENT_FLAGS, fl);
			wr(OFS_EVENT_FLAGS, 16'h0001 << b);
			rd(OFS_EVENT_FLAGS, fl);
		end
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr <= OFS_EVENT_FLAGS;
		i_wdata <= 16'h0008;
		ev <= 10'h008;
		@(posedge i_clock);
		i_write <= 1'b0;
		ev <= '0;
		fl[3] = 1'b1;
		rd(OFS_EVENT_FLAGS, fl);
		wr(OFS_EVENT_FLAGS, 16'h0008);
		rd(OFS_EVENT_FLAGS, fl);
		$display("test events done");
		wr(OFS_ENABLE_SET, 16'h0005);
		frm(1'b1, 1'b0, 11'h5A3, 1'b1);
		rd(OFS_FRAME_NUMBER, {2'b10, 11'h5A3, 3'h0});
		frm(1'b0, 1'b1, 11'h005, 1'b0);
		rd(OFS_FRAME_NUMBER, {2'b00, 11'h5A3, 3'h5});
		frm(1'b1, 1'b0, 11'h7FF, 1'b0);
		rd(OFS_FRAME_NUMBER, {2'b00, 11'h7FF, 3'h0});
		frm(1'b0, 1'b1, 11'h003, 1'b1);
		rd(OFS_FRAME_NUMBER, {2'b10, 11'h7FF, 3'h3});
		@(posedge i_clock);
		i_bus_reset <= 1'b1;
		@(posedge i_clock);
		i_bus_reset <= 1'b0;
		rd(OFS_FRAME_NUMBER, 16'h0000);
		wr(OFS_EVENT_FLAGS, 16'h0004);
		$display("test frame done");
		idle <= 1'b1;
		repeat (3) @(posedge i_clock);
		rd(OFS_EVENT_FLAGS, fl);
		repeat (8) @(posedge i_clock);
		fl[0] = 1'b1;
		rd(OFS_EVENT_FLAGS, fl);
		@(posedge i_clock);
		idle <= 1'b0;
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rst_n <= 1'b1;
		en = '0;
		fl = '0;
		rd(OFS_ENABLE_SET, 16'h0000);
		rd(OFS_EVENT_FLAGS, 16'h0000);
		rd(OFS_FRAME_NUMBER, 16'h0000);
		$display("test suspend done");
		test_done();
	end
endmodule
